// file: rtl/smsd_key_compare.sv
// per-component inclusive range test of a texel against a chroma key
`timescale 1ns/1ps
module smsd_key_compare (
    input wire logic [31:0] texel,
    input wire smsd_pkg::smsd_key_t key,
    input wire logic [3:0] signedChan,
    output logic match
);
    // sign-magnitude key byte to an unsigned order
    function automatic logic [7:0] smOrder(input logic [7:0] v);
        logic [7:0] tc;
        tc = v[7] ? 8'(-{1'b0, v[6:0]}) : v;
        return {~tc[7], tc[6:0]};
    endfunction

    // two's complement texel byte to an unsigned order
    function automatic logic [7:0] tcOrder(input logic [7:0] v);
        return {~v[7], v[6:0]};
    endfunction

    // all four components must lie between low and high inclusive
    always_comb begin
        logic [7:0] t;
        logic [7:0] lo;
        logic [7:0] hi;
        t = 8'h00;
        lo = 8'h00;
        hi = 8'h00;
        match = 1'b1;
        for (int c = 0; c < 4; c++) begin
            t = texel[c*8 +: 8];
            lo = key.low[c*8 +: 8];
            hi = key.high[c*8 +: 8];
            if (signedChan[c]) begin
                t = tcOrder(t);
                lo = smOrder(lo);
                hi = smOrder(hi);
            end
            if (t < lo || t > hi) begin
                match = 1'b0;
            end
        end
    end
endmodule

// file: rtl/smsd_palette_ram.sv
// palette storage with one write port and a registered read port
`timescale 1ns/1ps
module smsd_palette_ram #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrIdx,
    input wire logic [31:0] wrData,
    input wire logic [AW-1:0] rdIdx,
    output logic [31:0] rdData
);
    // entry array
    logic [31:0] mem [DEPTH];

    // write and registered read
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrIdx] <= wrData;
        end
        rdData <= mem[rdIdx];
    end
endmodule

// file: rtl/smsd_pkg.sv
// types shared by the sampler state and message decoder
package smsd_pkg;
    // simd widths, codes as in the newest descriptor
    typedef enum logic [1:0] {SIMD4X2 = 2'h0, SIMD8 = 2'h1, SIMD16 = 2'h2, SIMD32 = 2'h3} smsd_simd_t;
    // data return formats
    typedef enum logic [1:0] {RET_FLOAT = 2'h0, RET_RSVD = 2'h1, RET_UNSIGNED = 2'h2, RET_SIGNED = 2'h3} smsd_ret_t;
    // descriptor generations
    typedef enum logic [1:0] {DESC_OLDEST = 2'h0, DESC_TYPE4 = 2'h1, DESC_NEWEST = 2'h2} smsd_gen_t;
    // surface classes for return selection
    typedef enum logic [1:0] {SURF_OTHER = 2'h0, SURF_UINT = 2'h1, SURF_SINT = 2'h2} smsd_surf_t;
    // command parser states
    typedef enum logic [2:0] {
        ST_HDR = 3'h0, ST_KEY_IDX = 3'h1, ST_KEY_LOW = 3'h2, ST_KEY_HIGH = 3'h3,
        ST_PAL0 = 3'h4, ST_PAL1 = 3'h5, ST_MONO = 3'h6, ST_SKIP = 3'h7
    } smsd_state_t;
    // one message request
    typedef struct packed {
        logic [31:0] desc;
        logic [15:0] execMask;
        logic [3:0] hdrChanMask;
        smsd_gen_t gen;
        smsd_simd_t simdIn;
        smsd_surf_t surf;
        logic lodNeeded;
    } smsd_msg_in_t;
    // decoded message
    typedef struct packed {
        logic [15:0] pixelValid;
        logic [15:0] lodValid;
        logic [3:0] chanWrite;
        smsd_simd_t simd;
        logic [3:0] msgType;
        logic [3:0] samplerIdx;
        logic samplerUsed;
        logic [7:0] bindingIdx;
        smsd_ret_t retFormat;
        logic headerPresent;
        logic endThreadErr;
    } smsd_msg_out_t;
    // one chroma key range
    typedef struct packed {
        logic [31:0] low;
        logic [31:0] high;
    } smsd_key_t;
endpackage

// file: rtl/smsd_regs.svh
// command field positions, opcodes, descriptor fields and sizes for the sampler front end
`ifndef SMSD_REGS_SVH
`define SMSD_REGS_SVH
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// - key match: every component within inclusive range
// - signed channels: key is sign-magnitude, positive zero
// - first palette load: 3h/3h/1h/02h, length total-2
// - newer parts: N entries from index 0, 256
// - older parts: 16 colour-only entries, from 0
// - first palette dword: alpha 31:24, RGB 23:0
// - second palette load 0Ch: 256 entries from 0
// - second palette dword: packed alpha red green blue
// - mono filter width bits 5:3, needs enable
// - mono filter height bits 2:0, needs enable
// - 16-wide: mask selects pixels, others untouched
// - lod subspan: force UL, UR, LL valid
// - 8-wide: low eight mask bits are valid
// - 4x2: two groups of four, any bit
// - 4x2: channel write mask picks written channels
// - 32-wide: ignore mask, all pixels and channels
// - oldest descriptor: type 15:14, return 13:12
// - sampler index 11:8, binding table 7:0
// - 4-bit type: return follows surface class
// - header present bit 19, absent means zero
// - newest descriptor simd code bits 17:16

// command header fields
`define SMSD_CMD_TYPE_HI 31
`define SMSD_CMD_TYPE_LO 29
`define SMSD_CMD_SUBT_HI 28
`define SMSD_CMD_SUBT_LO 27
`define SMSD_CMD_OPC_HI 26
`define SMSD_CMD_OPC_LO 24
`define SMSD_CMD_SUBOP_HI 23
`define SMSD_CMD_SUBOP_LO 16
`define SMSD_CMD_LEN_HI 7
`define SMSD_CMD_LEN_LO 0
`define SMSD_PIPE_CLASS 3'h3
`define SMSD_PIPE_SUBTYPE 2'h3
`define SMSD_STATE_OPCODE 3'h1
`define SMSD_SUBOP_KEY 8'h04
`define SMSD_SUBOP_PAL0 8'h02
`define SMSD_SUBOP_PAL1 8'h0c
`define SMSD_SUBOP_MONO 8'h11
// palette sizes
`define SMSD_PAL_FULL 9'h100
`define SMSD_PAL_OLD 9'h010
`define SMSD_OLD_ALPHA 8'hff
// descriptor fields
`define SMSD_D_HDR 19
`define SMSD_D_EOT 31
`define SMSD_TYPE_LOAD 4'h7
`define SMSD_TYPE_RESINFO 4'ha
`define SMSD_OLD_TYPE_LOAD 2'h3
`endif

// file: rtl/smsd_sampler_front.sv
// sampler front end: state command parser, palettes, key test and message decode
`timescale 1ns/1ps
`include "smsd_regs.svh"
module smsd_sampler_front #(
    parameter int PAL_DEPTH = 256,
    parameter int PAL_AW = 8
) (
    input wire logic clk,
    input wire logic rst,
    // command stream, one dword a cycle
    input wire logic cmdValid,
    input wire logic [31:0] cmdData,
    // part selection: older parts have a small colour-only palette
    input wire logic olderPart,
    // monochrome filter enable from sampler state
    input wire logic monoEnable,
    // palette lookups
    input wire logic [PAL_AW-1:0] pal0RdIdx,
    input wire logic [PAL_AW-1:0] pal1RdIdx,
    output logic [31:0] pal0RdData,
    output logic [31:0] pal1RdData,
    // chroma key test
    input wire logic texelValid,
    input wire logic [31:0] texel,
    input wire logic [1:0] texelKeyIdx,
    input wire logic [3:0] texelSigned,
    output logic keyMatchValid,
    output logic keyMatch,
    // monochrome filter size in use
    output logic [2:0] monoWidth,
    output logic [2:0] monoHeight,
    output logic monoActive,
    // sampling messages
    input wire logic msgValid,
    input wire smsd_pkg::smsd_msg_in_t msgIn,
    output logic msgOutValid,
    output smsd_pkg::smsd_msg_out_t msgOut
);
    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    typedef struct packed {
        smsd_pkg::smsd_state_t st;        // parser state
        logic [7:0] remain;               // payload dwords after the current one
        logic [8:0] wrIdx;                // next palette entry
        logic [1:0] keyIdx;               // key entry being loaded
        smsd_pkg::smsd_key_t [3:0] keys;  // key table
        logic [2:0] monoW;                // programmed width
        logic [2:0] monoH;                // programmed height
        logic [2:0] monoWOut;             // width presented
        logic [2:0] monoHOut;             // height presented
        logic monoActOut;                 // filter in use
        logic keyVld;                     // key result valid
        logic keyHit;                     // key result
        logic msgVld;                     // decode valid
        smsd_pkg::smsd_msg_out_t msg;     // decode result
    } smsd_front_t;

    smsd_front_t s_r;  // registered state
    smsd_front_t s_nxt; // next state

    // palette write controls from the parser
    logic pal0Wr;
    logic pal1Wr;
    logic [31:0] palWrData;
    logic keyHitNow;

    //------------------------------------------------------------
    // helper functions
    //------------------------------------------------------------
    // pixel valid mask for one simd width
    function automatic logic [15:0] pixelMask(input smsd_pkg::smsd_simd_t simd, input logic [15:0] em);
        unique case (simd)
            smsd_pkg::SIMD16: pixelMask = em;
            smsd_pkg::SIMD8: pixelMask = {8'h00, em[7:0]};
            smsd_pkg::SIMD4X2: pixelMask = {14'h0000, |em[7:4], |em[3:0]};
            smsd_pkg::SIMD32: pixelMask = 16'hffff;
        endcase
    endfunction

    // lod needs upper left, upper right, lower left of live subspans
    function automatic logic [15:0] lodMask(input logic [15:0] pv);
        logic [15:0] m;
        m = pv;
        for (int q = 0; q < 4; q++) begin
            if (|pv[q*4 +: 4]) begin
                m[q*4 +: 3] = 3'h7;
            end
        end
        return m;
    endfunction

    // length field gives payload dwords as length plus one
    function automatic logic [7:0] payloadLen(input logic [31:0] h);
        return h[`SMSD_CMD_LEN_HI:`SMSD_CMD_LEN_LO];
    endfunction

    //------------------------------------------------------------
    // submodules
    //------------------------------------------------------------
    // first palette
    smsd_palette_ram #(.DEPTH(PAL_DEPTH), .AW(PAL_AW)) u_pal0 (
        .clk(clk),
        .wrEn(pal0Wr),
        .wrIdx(s_r.wrIdx[PAL_AW-1:0]),
        .wrData(palWrData),
        .rdIdx(pal0RdIdx),
        .rdData(pal0RdData)
    );

    // second palette
    smsd_palette_ram #(.DEPTH(PAL_DEPTH), .AW(PAL_AW)) u_pal1 (
        .clk(clk),
        .wrEn(pal1Wr),
        .wrIdx(s_r.wrIdx[PAL_AW-1:0]),
        .wrData(palWrData),
        .rdIdx(pal1RdIdx),
        .rdData(pal1RdData)
    );

    // key range test against the selected entry
    smsd_key_compare u_key (
        .texel(texel),
        .key(s_r.keys[texelKeyIdx]),
        .signedChan(texelSigned),
        .match(keyHitNow)
    );

    //------------------------------------------------------------
    // command parser
    //------------------------------------------------------------
    // palette writes happen on payload dwords within capacity
    always_comb begin
        logic [8:0] limit;
        limit = olderPart ? `SMSD_PAL_OLD : `SMSD_PAL_FULL;
        pal0Wr = 1'b0;
        pal1Wr = 1'b0;
        palWrData = cmdData;
        if (s_r.st == smsd_pkg::ST_PAL0) begin
            // older parts store colour only, alpha forced opaque
            palWrData = olderPart ? {`SMSD_OLD_ALPHA, cmdData[23:0]} : cmdData;
            pal0Wr = cmdValid && (s_r.wrIdx < limit);
        end
        if (s_r.st == smsd_pkg::ST_PAL1) begin
            pal1Wr = cmdValid && (s_r.wrIdx < `SMSD_PAL_FULL);
        end
    end

    // next state of parser, key table, mono size and message decode
    always_comb begin
        logic [31:0] d;
        logic hdrOk;
        smsd_pkg::smsd_simd_t simd;
        logic [3:0] chanMask;
        logic [3:0] mtype;
        d = cmdData;
        hdrOk = 1'b0;
        simd = smsd_pkg::SIMD16;
        chanMask = 4'h0;
        mtype = 4'h0;
        s_nxt = s_r;

        // one dword taken per valid cycle
        if (cmdValid) begin
            unique case (s_r.st)
                smsd_pkg::ST_HDR: begin
                    // reserved bits 15:8 are not checked
                    hdrOk = d[`SMSD_CMD_TYPE_HI:`SMSD_CMD_TYPE_LO] == `SMSD_PIPE_CLASS &&
                            d[`SMSD_CMD_SUBT_HI:`SMSD_CMD_SUBT_LO] == `SMSD_PIPE_SUBTYPE &&
                            d[`SMSD_CMD_OPC_HI:`SMSD_CMD_OPC_LO] == `SMSD_STATE_OPCODE;
                    s_nxt.remain = payloadLen(d);
                    s_nxt.wrIdx = 9'h000;
                    if (!hdrOk) begin
                        s_nxt.st = smsd_pkg::ST_SKIP;
                    end else if (d[`SMSD_CMD_SUBOP_HI:`SMSD_CMD_SUBOP_LO] == `SMSD_SUBOP_KEY) begin
                        s_nxt.st = smsd_pkg::ST_KEY_IDX;
                    end else if (d[`SMSD_CMD_SUBOP_HI:`SMSD_CMD_SUBOP_LO] == `SMSD_SUBOP_PAL0) begin
                        s_nxt.st = smsd_pkg::ST_PAL0;
                    end else if (d[`SMSD_CMD_SUBOP_HI:`SMSD_CMD_SUBOP_LO] == `SMSD_SUBOP_PAL1) begin
                        s_nxt.st = smsd_pkg::ST_PAL1;
                    end else if (d[`SMSD_CMD_SUBOP_HI:`SMSD_CMD_SUBOP_LO] == `SMSD_SUBOP_MONO) begin
                        s_nxt.st = smsd_pkg::ST_MONO;
                    end else begin
                        s_nxt.st = smsd_pkg::ST_SKIP;
                    end
                end
                smsd_pkg::ST_KEY_IDX: begin
                    // table index in 31:30, rest reserved
                    s_nxt.keyIdx = d[31:30];
                    s_nxt.st = smsd_pkg::ST_KEY_LOW;
                end
                smsd_pkg::ST_KEY_LOW: begin
                    s_nxt.keys[s_r.keyIdx].low = d;
                    s_nxt.st = smsd_pkg::ST_KEY_HIGH;
                end
                smsd_pkg::ST_KEY_HIGH: begin
                    s_nxt.keys[s_r.keyIdx].high = d;
                    s_nxt.st = smsd_pkg::ST_HDR;
                end
                smsd_pkg::ST_PAL0, smsd_pkg::ST_PAL1: begin
                    // short loads end on the length field
                    s_nxt.wrIdx = s_r.wrIdx + 9'h001;
                    s_nxt.remain = s_r.remain - 8'h01;
                    if (s_r.remain == 8'h00) begin
                        s_nxt.st = smsd_pkg::ST_HDR;
                    end
                end
                smsd_pkg::ST_MONO: begin
                    s_nxt.monoW = d[5:3];
                    s_nxt.monoH = d[2:0];
                    s_nxt.st = smsd_pkg::ST_HDR;
                end
                smsd_pkg::ST_SKIP: begin
                    // unknown commands are passed over by length
                    s_nxt.remain = s_r.remain - 8'h01;
                    if (s_r.remain == 8'h00) begin
                        s_nxt.st = smsd_pkg::ST_HDR;
                    end
                end
            endcase
        end

        // monochrome size only presented while filtering is enabled
        s_nxt.monoActOut = monoEnable;
        s_nxt.monoWOut = monoEnable ? s_r.monoW : 3'h0;
        s_nxt.monoHOut = monoEnable ? s_r.monoH : 3'h0;

        // chroma key result one cycle after the texel
        s_nxt.keyVld = texelValid;
        s_nxt.keyHit = texelValid && keyHitNow;

        //--------------------------------------------------------
        // message decode
        //--------------------------------------------------------
        s_nxt.msgVld = msgValid;
        if (msgValid) begin
            // simd width from the newest descriptor, else supplied
            simd = (msgIn.gen == smsd_pkg::DESC_NEWEST) ?
                   smsd_pkg::smsd_simd_t'(msgIn.desc[17:16]) : msgIn.simdIn;
            // absent header reads as all zero: every channel enabled
            s_nxt.msg.headerPresent = (msgIn.gen == smsd_pkg::DESC_NEWEST) && msgIn.desc[`SMSD_D_HDR];
            chanMask = s_nxt.msg.headerPresent ? msgIn.hdrChanMask : 4'h0;
            s_nxt.msg.simd = simd;
            s_nxt.msg.pixelValid = pixelMask(simd, msgIn.execMask);
            s_nxt.msg.lodValid = (msgIn.lodNeeded && simd != smsd_pkg::SIMD32 && simd != smsd_pkg::SIMD4X2) ?
                                 lodMask(s_nxt.msg.pixelValid) : s_nxt.msg.pixelValid;
            // channels: 4x2 uses write mask, 32-wide returns all
            s_nxt.msg.chanWrite = (simd == smsd_pkg::SIMD32) ? 4'hf : ~chanMask;
            s_nxt.msg.bindingIdx = msgIn.desc[7:0];
            s_nxt.msg.samplerIdx = msgIn.desc[11:8];
            s_nxt.msg.endThreadErr = msgIn.desc[`SMSD_D_EOT];
            if (msgIn.gen == smsd_pkg::DESC_OLDEST) begin
                // two-bit type and explicit return format
                mtype = {2'h0, msgIn.desc[15:14]};
                s_nxt.msg.retFormat = smsd_pkg::smsd_ret_t'(msgIn.desc[13:12]);
                s_nxt.msg.samplerUsed = msgIn.desc[15:14] != `SMSD_OLD_TYPE_LOAD;
            end else begin
                // four-bit type, return follows the surface
                mtype = msgIn.desc[15:12];
                if (mtype == `SMSD_TYPE_RESINFO || msgIn.surf == smsd_pkg::SURF_UINT) begin
                    s_nxt.msg.retFormat = smsd_pkg::RET_UNSIGNED;
                end else if (msgIn.surf == smsd_pkg::SURF_SINT) begin
                    s_nxt.msg.retFormat = smsd_pkg::RET_SIGNED;
                end else begin
                    s_nxt.msg.retFormat = smsd_pkg::RET_FLOAT;
                end
                s_nxt.msg.samplerUsed = mtype != `SMSD_TYPE_LOAD && mtype != `SMSD_TYPE_RESINFO;
            end
            s_nxt.msg.msgType = mtype;
        end
    end

    //------------------------------------------------------------
    // state register
    //------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    //------------------------------------------------------------
    // outputs
    //------------------------------------------------------------
    assign keyMatchValid = s_r.keyVld;
    assign keyMatch = s_r.keyHit;
    assign monoWidth = s_r.monoWOut;
    assign monoHeight = s_r.monoHOut;
    assign monoActive = s_r.monoActOut;
    assign msgOutValid = s_r.msgVld;
    assign msgOut = s_r.msg;
endmodule

// file: verif/smsd_sampler_front_bench.sv
// self-checking bench for the sampler front end
`timescale 1ns/1ps
module smsd_sampler_front_bench;
    logic clk, rst, olderPart, monoEnable, texelValid, keyMatchValid, keyMatch, monoActive;
    logic cmdValid, msgValid, msgOutValid;
    logic [7:0] pal0RdIdx, pal1RdIdx;
    logic [31:0] pal0RdData, pal1RdData, texel, cmdData;
    logic [1:0] texelKeyIdx;
    logic [3:0] texelSigned;
    logic [2:0] monoWidth, monoHeight;
    smsd_pkg::smsd_msg_in_t msgIn;
    smsd_pkg::smsd_msg_out_t msgOut;
    int errors = 0;
    int checks = 0;
    smsd_sampler_front u_smsd_sampler_front (.*);
    smsd_stream_source u_smsd_stream_source (.*);
    // one command dword through the streamer model
    task automatic pc(input logic [31:0] d);
        u_smsd_stream_source.put_cmd(d);
    endtask
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // registered palette read of both tables
    task automatic pal_rd(input logic [7:0] i, output logic [31:0] d0, output logic [31:0] d1);
        @(posedge clk);
        pal0RdIdx <= i;
        pal1RdIdx <= i;
        @(posedge clk);
        #1;
        d0 = pal0RdData;
        d1 = pal1RdData;
    endtask
    task automatic t_palettes();
        logic [31:0] d0, d1;
        pc(32'h7902ab01);
        pc(32'h11223344);
        pc(32'h55667788);
        pc(32'h790c0000);
        pc(32'h99aabbcc);
        u_smsd_stream_source.end_cmd();
        pal_rd(8'h00, d0, d1);
        chk("pal0 entry0", d0, 32'h11223344);
        chk("pal1 entry0", d1, 32'h99aabbcc);
        pal_rd(8'h01, d0, d1);
        chk("pal0 entry1", d0, 32'h55667788);
        @(posedge clk);
        olderPart <= 1'b1;
        pc(32'h79020000);
        pc(32'h00abcdef);
        u_smsd_stream_source.end_cmd();
        pal_rd(8'h00, d0, d1);
        chk("small entry0", d0, 32'hffabcdef);
        pal_rd(8'h01, d0, d1);
        chk("small entry1 kept", d0, 32'h55667788);
        $display("test palettes done");
    endtask
    task automatic t_mono();
        pc(32'h79110000);
        pc(32'hffffffeb);
        u_smsd_stream_source.end_cmd();
        monoEnable <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("mono width", monoWidth, 3'h5);
        chk("mono height", monoHeight, 3'h3);
        @(posedge clk);
        monoEnable <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("mono width off", monoWidth, 3'h0);
        chk("mono height off", monoHeight, 3'h0);
        $display("test mono done");
    endtask
    // one texel against the key, answer one cycle later
    task automatic key_try(input logic [31:0] t, input logic exp);
        @(posedge clk);
        texelValid <= 1'b1;
        texel <= t;
        @(posedge clk);
        texelValid <= 1'b0;
        #1;
        chk("key valid", keyMatchValid, 1'b1);
        chk("key match", keyMatch, exp);
    endtask
    task automatic t_key();
        pc(32'h79040002);
        pc(32'h80000000);
        pc(32'h10101081);
        pc(32'h20202001);
        u_smsd_stream_source.end_cmd();
        texelKeyIdx <= 2'h2;
        texelSigned <= 4'h1;
        key_try(32'h10202000, 1'b1);
        key_try(32'h201010ff, 1'b1);
        key_try(32'h101010fe, 1'b0);
        key_try(32'h21101001, 1'b0);
        $display("test key done");
    endtask
    function automatic smsd_pkg::smsd_msg_in_t mk(input logic [31:0] d, input logic [15:0] m,
        input logic [3:0] h, input logic [1:0] g, input logic [1:0] s, input logic [1:0] f, input logic l);
        mk = {d, m, h, g, s, f, l};
    endfunction
    task automatic msg_chk(input smsd_pkg::smsd_msg_in_t m, input logic [15:0] pv, input logic [15:0] lv,
        input logic [3:0] cw, input logic [1:0] rf);
        u_smsd_stream_source.put_msg(m);
        #1;
        chk("msg valid", msgOutValid, 1'b1);
        chk("pixel valid", msgOut.pixelValid, pv);
        chk("lod valid", msgOut.lodValid, lv);
        chk("chan write", msgOut.chanWrite, cw);
        chk("ret format", msgOut.retFormat, rf);
        chk("bind idx", msgOut.bindingIdx, m.desc[7:0]);
    endtask
    task automatic t_msg();
        logic [1:0] rf;
        msg_chk(mk(32'h000a0312, 16'h8421, 4'h5, 2'h2, 2'h0, 2'h2, 1'b0), 16'h8421, 16'h8421, 4'ha, 2'h3);
        msg_chk(mk(32'h00010055, 16'hff3c, 4'h5, 2'h2, 2'h0, 2'h1, 1'b0), 16'h003c, 16'h003c, 4'hf, 2'h2);
        msg_chk(mk(32'h00080000, 16'hff10, 4'h3, 2'h2, 2'h0, 2'h0, 1'b0), 16'h0002, 16'h0002, 4'hc, 2'h0);
        msg_chk(mk(32'h00030000, 16'h0000, 4'hf, 2'h2, 2'h0, 2'h0, 1'b0), 16'hffff, 16'hffff, 4'hf, 2'h0);
        msg_chk(mk(32'h000a0000, 16'h0008, 4'h0, 2'h2, 2'h0, 2'h0, 1'b1), 16'h0008, 16'h000f, 4'hf, 2'h0);
        msg_chk(mk(32'h0000a540, 16'h00ff, 4'h0, 2'h1, 2'h1, 2'h2, 1'b0), 16'h00ff, 16'h00ff, 4'hf, 2'h2);
        chk("sampler used", msgOut.samplerUsed, 1'b0);
        for (int i = 0; i < 3; i++) begin
            rf = 2'(i + (i > 0));
            msg_chk(mk({18'h0, rf, 12'h301}, 16'h0001, 4'h0, 2'h0, 2'h2, 2'h0, 1'b0), 16'h0001, 16'h0001, 4'hf, rf);
        end
        $display("test messages done");
    endtask
    // hang guard
    initial begin
        #50000;
        errors++;
        close_out();
    end
    // reset, then the scenarios
    initial begin
        rst = 1'b1;
        olderPart = 1'b0;
        monoEnable = 1'b0;
        pal0RdIdx = 8'h00;
        pal1RdIdx = 8'h00;
        texelValid = 1'b0;
        texel = 32'h0;
        texelKeyIdx = 2'h0;
        texelSigned = 4'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("msg valid after reset", msgOutValid, 1'b0);
        t_palettes();
        t_mono();
        t_key();
        t_msg();
        close_out();
    end
endmodule

// file: verif/smsd_sampler_front_monitor.sv
// port-level checks of the sampler front end message decode and mono size
`timescale 1ns/1ps
module smsd_sampler_front_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic monoEnable,
    input wire logic [2:0] monoWidth,
    input wire logic [2:0] monoHeight,
    input wire logic msgValid,
    input wire smsd_pkg::smsd_msg_in_t msgIn,
    input wire logic msgOutValid,
    input wire smsd_pkg::smsd_msg_out_t msgOut
);
    // newest descriptor request this cycle
    logic isNew;
    assign isNew = msgValid && msgIn.gen == smsd_pkg::DESC_NEWEST;
    // simd code of the newest descriptor
    logic [1:0] sm;
    assign sm = msgIn.desc[17:16];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_mono_size_off: assert property (!monoEnable |=> monoWidth == 3'h0 && monoHeight == 3'h0)
        else $error("mono size shown while disabled");
    a_wide16_mask: assert property (isNew && sm == 2'h2 |=>
        msgOut.pixelValid == $past(msgIn.execMask)) else $error("16-wide pixels differ from mask");
    a_lod_subspan: assert property (isNew && sm == 2'h2 && msgIn.lodNeeded &&
        msgIn.execMask[3:0] != 4'h0 |=> msgOut.lodValid[2:0] == 3'h7) else $error("lod pixels not forced");
    a_wide8_low: assert property (isNew && sm == 2'h1 |=>
        msgOut.pixelValid == {8'h00, $past(msgIn.execMask[7:0])}) else $error("8-wide pixels wrong");
    a_group_4x2: assert property (isNew && sm == 2'h0 |=>
        msgOut.pixelValid[1:0] == {|$past(msgIn.execMask[7:4]), |$past(msgIn.execMask[3:0])})
        else $error("4x2 group validity wrong");
    a_chan_4x2: assert property (isNew && sm == 2'h0 && msgIn.desc[19] |=>
        msgOut.chanWrite == ~$past(msgIn.hdrChanMask)) else $error("4x2 channel write wrong");
    a_wide32_all: assert property (isNew && sm == 2'h3 |=>
        msgOut.pixelValid == 16'hffff && msgOut.chanWrite == 4'hf) else $error("32-wide not all valid");
    a_old_return: assert property (msgValid && msgIn.gen == smsd_pkg::DESC_OLDEST |=>
        msgOut.retFormat == $past(msgIn.desc[13:12])) else $error("oldest return format wrong");
    a_index_fields: assert property (msgValid |=> msgOutValid &&
        msgOut.bindingIdx == $past(msgIn.desc[7:0]) && msgOut.samplerIdx == $past(msgIn.desc[11:8]))
        else $error("index fields wrong");
    a_resinfo_uint: assert property (msgValid && msgIn.gen == smsd_pkg::DESC_TYPE4 &&
        msgIn.desc[15:12] == 4'ha |=> msgOut.retFormat == smsd_pkg::RET_UNSIGNED && !msgOut.samplerUsed)
        else $error("resource query return wrong");
    a_no_header: assert property (isNew && !msgIn.desc[19] |=> !msgOut.headerPresent &&
        msgOut.chanWrite == 4'hf) else $error("absent header not zero");
endmodule
bind smsd_sampler_front smsd_sampler_front_monitor u_smsd_sampler_front_monitor (.*);

// file: verif/smsd_stream_source.sv
// command streamer and sending thread standing at the far side
`timescale 1ns/1ps
module smsd_stream_source (
    input wire logic clk,
    output logic cmdValid,
    output logic [31:0] cmdData,
    output logic msgValid,
    output smsd_pkg::smsd_msg_in_t msgIn
);
    // idle at time zero
    initial begin
        cmdValid = 1'b0;
        cmdData = 32'h0;
        msgValid = 1'b0;
        msgIn = '0;
    end
    // one command dword per edge
    task automatic put_cmd(input logic [31:0] d);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdData <= d;
    endtask
    // frame over, data turns meaningless
    task automatic end_cmd();
        @(posedge clk);
        cmdValid <= 1'b0;
        cmdData <= ~cmdData;
    endtask
    // one message pulse, end-of-thread kept clear
    task automatic put_msg(input smsd_pkg::smsd_msg_in_t m);
        m.desc[31] = 1'b0;
        @(posedge clk);
        msgValid <= 1'b1;
        msgIn <= m;
        @(posedge clk);
        msgValid <= 1'b0;
        msgIn <= ~m;
    endtask
endmodule
